// >>> lpc_regs.vh
`ifndef LPC_REGS_VH
`define LPC_REGS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define LPC_ADDR_PAIR_ONE   8'h00
`define LPC_ADDR_PAIR_TWO   8'h01
`define LPC_ADDR_PAIR_THREE 8'h02
`define LPC_ADDR_ON_OFF     8'h03
`define LPC_REG_RESET       8'h00
`define LPC_CODE_MSB        5
`define LPC_ON_OFF_MSB      5
// ----------------------------------------
// bus
// ----------------------------------------
`define LPC_SLAVE_ADDR      7'h66
// ----------------------------------------
// timing
// ----------------------------------------
`define LPC_CLK_HZ          20000000
`define LPC_PUMP_DELAY_US   400
// divide first: the product of the two would overflow 32 bits
`define LPC_PUMP_DELAY_CYC  (`LPC_PUMP_DELAY_US * (`LPC_CLK_HZ / 1000000))
`endif

// >>> lpc_i2c_slave.v
`default_nettype none
module lpc_i2c_slave (
    input  wire       ref_clk_i,
    input  wire       rst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_oe_n_o,
    output reg        wr_stb_o,
    output reg  [7:0] wr_addr_o,
    output reg  [7:0] wr_data_o,
    output wire [7:0] rd_addr_o,
    input  wire [7:0] rd_data_i
);
`include "lpc_regs.vh"
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DEV  = 3'd1;
    localparam [2:0] ST_REG  = 3'd2;
    localparam [2:0] ST_WDAT = 3'd3;
    localparam [2:0] ST_RDAT = 3'd4;
    localparam [2:0] ST_MACK = 3'd5;

    reg  [1:0] scl_s_q;
    reg  [1:0] sda_s_q;
    reg        scl_q;
    reg        sda_q;
    reg  [2:0] st_q;
    reg  [3:0] bit_q;
    reg  [7:0] sh_q;
    reg        ack_q;
    reg  [7:0] ptr_q;

    wire scl_rise = scl_s_q[1] & ~scl_q;
    wire scl_fall = ~scl_s_q[1] & scl_q;
    wire start_c  = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    wire stop_c   = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];
    wire [7:0] sh_in = {sh_q[6:0], sda_s_q[1]};

    assign rd_addr_o = ptr_q;

    always @(posedge ref_clk_i) begin
        scl_s_q <= {scl_s_q[0], scl_i};
        sda_s_q <= {sda_s_q[0], sda_i};
        scl_q   <= scl_s_q[1];
        sda_q   <= sda_s_q[1];
        wr_stb_o <= 1'b0;
        if (rst_i) begin
            st_q       <= ST_IDLE;
            bit_q      <= 4'd0;
            sh_q       <= 8'h00;
            ack_q      <= 1'b0;
            ptr_q      <= 8'h00;
            sda_oe_n_o <= 1'b1;
            wr_addr_o  <= 8'h00;
            wr_data_o  <= 8'h00;
        end else if (start_c) begin
            st_q       <= ST_DEV;
            bit_q      <= 4'd0;
            ack_q      <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end else if (stop_c) begin
            st_q       <= ST_IDLE;
            sda_oe_n_o <= 1'b1;
        end else if (st_q != ST_IDLE) begin
            if (scl_rise && !ack_q) begin
                sh_q  <= sh_in;
                bit_q <= bit_q + 4'd1;
            end else if (scl_rise && ack_q && st_q == ST_MACK) begin
                // master nack ends the read burst
                if (sda_s_q[1])
                    st_q <= ST_IDLE;
                else
                    st_q <= ST_RDAT;
            end
            if (scl_fall) begin
                if (ack_q) begin
                    ack_q      <= 1'b0;
                    bit_q      <= 4'd0;
                    sda_oe_n_o <= 1'b1;
                    if (st_q == ST_RDAT) begin
                        sh_q       <= rd_data_i;
                        sda_oe_n_o <= rd_data_i[7];
                    end
                end else if (bit_q == 4'd8) begin
                    ack_q <= 1'b1;
                    case (st_q)
                    ST_DEV: begin
                        if (sh_q[7:1] == `LPC_SLAVE_ADDR) begin
                            sda_oe_n_o <= 1'b0;
                            st_q       <= sh_q[0] ? ST_RDAT : ST_REG;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                    ST_REG: begin
                        sda_oe_n_o <= 1'b0;
                        ptr_q      <= sh_q;
                        st_q       <= ST_WDAT;
                    end
                    ST_WDAT: begin
                        sda_oe_n_o <= 1'b0;
                        wr_stb_o   <= 1'b1;
                        wr_addr_o  <= ptr_q;
                        wr_data_o  <= sh_q;
                        ptr_q      <= ptr_q + 8'd1;
                    end
                    ST_RDAT: begin
                        sda_oe_n_o <= 1'b1;
                        ptr_q      <= ptr_q + 8'd1;
                        st_q       <= ST_MACK;
                    end
                    default: st_q <= ST_IDLE;
                    endcase
                end else if (st_q == ST_RDAT) begin
                    // shifter moves on every rise, next bit sits at the top
                    sda_oe_n_o <= sh_q[7];
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> lpc_led_ctrl.v
// Behaviour
// - four 8-bit registers at addresses 0..3
// - address 0 sets pair one current
// - address 1 sets pair two current
// - address 2 sets pair three current
// - on/off bits 0..5, one per sink
// - all registers writable and readable over bus
// - enable low: shutdown, currents zero
// - shutdown puts all sinks high-impedance
// - supply low lockout disables every sink
// - sequence starts in 1x pump mode
// - stay 1x while regulation sufficient
// - switch to 1.5x after 400 us
// - restart on power-up, enable, on/off write
// - low six bits code, upper ignored
// - answers only to address 1100110
// - write: address, register, data, acks
`default_nettype none
`include "lpc_regs.vh"
module lpc_led_ctrl #(
    parameter integer PUMP_DELAY_CYC = `LPC_PUMP_DELAY_CYC
) (
    input  wire       ref_clk_i,
    input  wire       rst_i,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_oe_n_o,
    input  wire       enable_i,
    input  wire       supply_low_lockout_i,
    input  wire       regulation_ok_i,
    output reg  [5:0] pair_one_code_o,
    output reg  [5:0] pair_two_code_o,
    output reg  [5:0] pair_three_code_o,
    output reg  [5:0] sink_on_o,
    output reg  [5:0] sink_hiz_o,
    output reg        pump_1p5x_o
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg  [1:0] en_s_q;
    reg  [1:0] uv_s_q;
    reg  [1:0] reg_s_q;
    reg        en_d_q;
    always @(posedge ref_clk_i) begin
        en_s_q  <= {en_s_q[0], enable_i};
        uv_s_q  <= {uv_s_q[0], supply_low_lockout_i};
        reg_s_q <= {reg_s_q[0], regulation_ok_i};
        en_d_q  <= rst_i ? 1'b0 : en_s_q[1];
    end
    wire en_on   = en_s_q[1];
    wire en_rise = en_s_q[1] & ~en_d_q;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    wire       sda_oe_n;
    wire       wr_stb;
    wire [7:0] wr_addr;
    wire [7:0] wr_data;
    wire [7:0] rd_addr;
    reg  [7:0] rd_data;
    // bus held idle in shutdown
    wire       bus_rst = rst_i | ~en_on;

    lpc_i2c_slave u_slave (
        .ref_clk_i  (ref_clk_i),
        .rst_i      (bus_rst),
        .scl_i      (scl_i),
        .sda_i      (sda_i),
        .sda_oe_n_o (sda_oe_n),
        .wr_stb_o   (wr_stb),
        .wr_addr_o  (wr_addr),
        .wr_data_o  (wr_data),
        .rd_addr_o  (rd_addr),
        .rd_data_i  (rd_data)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] pair_one_current_q;
    reg [7:0] pair_two_current_q;
    reg [7:0] pair_three_current_q;
    reg [7:0] channel_on_off_q;
    reg [7:0] pair_one_current_d;
    reg [7:0] pair_two_current_d;
    reg [7:0] pair_three_current_d;
    reg [7:0] channel_on_off_d;

    always @* begin
        pair_one_current_d   = pair_one_current_q;
        pair_two_current_d   = pair_two_current_q;
        pair_three_current_d = pair_three_current_q;
        channel_on_off_d     = channel_on_off_q;
        if (wr_stb) begin
            case (wr_addr)
            `LPC_ADDR_PAIR_ONE:   pair_one_current_d   = wr_data;
            `LPC_ADDR_PAIR_TWO:   pair_two_current_d   = wr_data;
            `LPC_ADDR_PAIR_THREE: pair_three_current_d = wr_data;
            `LPC_ADDR_ON_OFF:     channel_on_off_d     = wr_data;
            // unknown addresses are acked but change nothing
            default: ;
            endcase
        end
    end

    always @(posedge ref_clk_i) begin
        if (rst_i || !en_on) begin
            pair_one_current_q   <= `LPC_REG_RESET;
            pair_two_current_q   <= `LPC_REG_RESET;
            pair_three_current_q <= `LPC_REG_RESET;
            channel_on_off_q     <= `LPC_REG_RESET;
        end else begin
            pair_one_current_q   <= pair_one_current_d;
            pair_two_current_q   <= pair_two_current_d;
            pair_three_current_q <= pair_three_current_d;
            channel_on_off_q     <= channel_on_off_d;
        end
    end

    always @* begin
        case (rd_addr)
        `LPC_ADDR_PAIR_ONE:   rd_data = pair_one_current_q;
        `LPC_ADDR_PAIR_TWO:   rd_data = pair_two_current_q;
        `LPC_ADDR_PAIR_THREE: rd_data = pair_three_current_q;
        `LPC_ADDR_ON_OFF:     rd_data = channel_on_off_q;
        default:              rd_data = 8'h00;
        endcase
    end

    wire onoff_wr = wr_stb && (wr_addr == `LPC_ADDR_ON_OFF);

    // ----------------------------------------
    // pump mode sequencer
    // ----------------------------------------
    localparam [1:0] PM_1X   = 2'd0;
    localparam [1:0] PM_WAIT = 2'd1;
    localparam [1:0] PM_1P5X = 2'd2;
    // last count before the switch; entry and output take the other two
    localparam [15:0] DLY_LAST = PUMP_DELAY_CYC[15:0] - 16'd2;
    reg  [1:0]  pm_q;
    reg  [1:0]  pm_d;
    reg  [15:0] dly_q;
    reg  [15:0] dly_d;
    wire        reg_ok = reg_s_q[1];
    // power-up seen through rst_i; restart also on enable rise / on/off write
    wire restart = rst_i | ~en_on | en_rise | onoff_wr;

    always @* begin
        pm_d  = pm_q;
        dly_d = dly_q;
        if (restart) begin
            pm_d  = PM_1X;
            dly_d = 16'd0;
        end else begin
            case (pm_q)
            PM_1X: begin
                dly_d = 16'd0;
                if (!reg_ok)
                    pm_d = PM_WAIT;
            end
            PM_WAIT: begin
                if (reg_ok) begin
                    pm_d = PM_1X;
                end else if (dly_q == DLY_LAST) begin
                    pm_d = PM_1P5X;
                end else begin
                    dly_d = dly_q + 16'd1;
                end
            end
            // only a restart brings the pump back to 1x
            PM_1P5X: pm_d = PM_1P5X;
            default: pm_d = PM_1X;
            endcase
        end
    end

    always @(posedge ref_clk_i) begin
        pm_q  <= pm_d;
        dly_q <= dly_d;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // upper two bits of a current register carry no meaning
    function [5:0] code_field;
        input [7:0] r;
        begin
            code_field = r[`LPC_CODE_MSB:0];
        end
    endfunction

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always @(posedge ref_clk_i) begin
        if (rst_i) begin
            sda_oe_n_o        <= 1'b1;
            pair_one_code_o   <= 6'd0;
            pair_two_code_o   <= 6'd0;
            pair_three_code_o <= 6'd0;
            sink_on_o         <= 6'd0;
            sink_hiz_o        <= 6'h3f;
            pump_1p5x_o       <= 1'b0;
        end else begin
            sda_oe_n_o        <= sda_oe_n;
            pair_one_code_o   <= code_field(pair_one_current_q);
            pair_two_code_o   <= code_field(pair_two_current_q);
            pair_three_code_o <= code_field(pair_three_current_q);
            if (!en_on || uv_s_q[1])
                sink_on_o <= 6'd0;
            else
                sink_on_o <= channel_on_off_q[`LPC_ON_OFF_MSB:0];
            sink_hiz_o  <= en_on ? 6'h00 : 6'h3f;
            pump_1p5x_o <= (pm_q == PM_1P5X);
        end
    end
endmodule
`default_nettype wire

// >>> lpc_led_ctrl_properties.sv
`default_nettype none
module lpc_led_ctrl_properties #(
    parameter integer PUMP_DELAY_CYC = 20
) (
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_oe_n_o,
    input wire logic       enable_i,
    input wire logic       supply_low_lockout_i,
    input wire logic       regulation_ok_i,
    input wire logic [5:0] pair_one_code_o,
    input wire logic [5:0] pair_two_code_o,
    input wire logic [5:0] pair_three_code_o,
    input wire logic [5:0] sink_on_o,
    input wire logic [5:0] sink_hiz_o,
    input wire logic       pump_1p5x_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------
    // checks
    // --------
    // raw pin count: design sees it later, so this only over-counts
    logic [15:0] low_cnt_q;
    always_ff @(posedge ref_clk_i)
        if (rst_i || regulation_ok_i)
            low_cnt_q <= 16'h0000;
        else if (low_cnt_q != 16'hffff)
            low_cnt_q <= low_cnt_q + 16'h0001;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_reset_vals;
        disable iff (1'b0) rst_i |=> sink_on_o == 6'h00
            && sink_hiz_o == 6'h3f && !pump_1p5x_o && sda_oe_n_o;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs not cleared by reset");
    property p_shutdown_hiz;
        !enable_i [*6] |-> sink_hiz_o == 6'h3f && sink_on_o == 6'h00;
    endproperty
    a_shutdown_hiz: assert property (p_shutdown_hiz)
        else $error("sinks not released in shutdown");
    property p_codes_shutdown;
        !enable_i [*6] |-> {pair_one_code_o, pair_two_code_o,
            pair_three_code_o} == 18'h0_0000;
    endproperty
    a_codes_shutdown: assert property (p_codes_shutdown)
        else $error("codes kept through shutdown");
    property p_hiz_excl;
        (|sink_hiz_o) |-> sink_on_o == 6'h00;
    endproperty
    a_hiz_excl: assert property (p_hiz_excl)
        else $error("sink on while released");
    property p_uv_off;
        supply_low_lockout_i [*6] |-> sink_on_o == 6'h00;
    endproperty
    a_uv_off: assert property (p_uv_off)
        else $error("sink on under lockout");
    property p_stay_1x;
        (regulation_ok_i && !pump_1p5x_o) [*6] |=> !pump_1p5x_o;
    endproperty
    a_stay_1x: assert property (p_stay_1x)
        else $error("pump left 1x while regulated");
    property p_pump_delay;
        $rose(pump_1p5x_o) |-> low_cnt_q >= PUMP_DELAY_CYC;
    endproperty
    a_pump_delay: assert property (p_pump_delay)
        else $error("pump switched too early");
    property p_restart_1x;
        $rose(enable_i) |-> ##[1:6] !pump_1p5x_o;
    endproperty
    a_restart_1x: assert property (p_restart_1x)
        else $error("no 1x restart after enable");
    property p_sda_scl_low;
        $changed(sda_oe_n_o) |-> !scl_i;
    endproperty
    a_sda_scl_low: assert property (p_sda_scl_low)
        else $error("data line moved while clock high");

    c_pump: cover property ($rose(pump_1p5x_o));
    c_ack: cover property ($fell(sda_oe_n_o));
    c_all_on: cover property (sink_on_o == 6'h3f);
endmodule
`default_nettype wire

// >>> lpc_i2c_host.sv
`default_nettype none
module lpc_i2c_host (
    input  wire logic dev_oe_n_i,
    output var  logic scl_o,
    output wire logic sda_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // --------
    // bus master, clock low 300 ns, high 100 ns
    // --------
    // long low phase leaves room for the slave's synchroniser latency
    logic pull_low = 1'b0;
    initial scl_o = 1'b1;
    assign sda_o = dev_oe_n_i & !pull_low;

    task automatic clk_bit(input logic b, output logic r);
        #100 pull_low = !b;
        #200 scl_o = 1'b1;
        #100 r = sda_o;
        scl_o = 1'b0;
    endtask
    // full low phase before raising the clock: the slave's ack release
    // lands about 200 ns after the previous fall
    task automatic start;
        #100 pull_low = 1'b0;
        #200 scl_o = 1'b1;
        #100 pull_low = 1'b1;
        #100 scl_o = 1'b0;
    endtask
    task automatic stop;
        #100 pull_low = 1'b1;
        #200 scl_o = 1'b1;
        #100 pull_low = 1'b0;
        #100;
    endtask
    task automatic byte_x(input logic [7:0] d, input logic mack,
                          output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
        clk_bit(mack, ack);
    endtask
    task automatic write(input logic [6:0] dev, input logic [7:0] a,
                         input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       k0, k1, k2;
        start;
        byte_x({dev, 1'b0}, 1'b1, q, k0);
        byte_x(a, 1'b1, q, k1);
        byte_x(d, 1'b1, q, k2);
        stop;
        ok = !(k0 | k1 | k2);
    endtask
    task automatic read(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] q;
        logic       k;
        start;
        byte_x({7'h66, 1'b0}, 1'b1, q, k);
        byte_x(a, 1'b1, q, k);
        start;
        byte_x({7'h66, 1'b1}, 1'b1, q, k);
        byte_x(8'hff, 1'b1, d, k);
        stop;
    endtask
endmodule
`default_nettype wire

// >>> lpc_led_ctrl_tb.sv
`default_nettype none
module lpc_led_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam integer PD = 20;
    logic       ref_clk_i, rst_i = 1'b1, enable_i = 1'b0;
    logic       supply_low_lockout_i = 1'b0, regulation_ok_i = 1'b1;
    wire        scl_i, sda_i, sda_oe_n_o, pump_1p5x_o;
    wire  [5:0] pair_one_code_o, pair_two_code_o, pair_three_code_o;
    wire  [5:0] sink_on_o, sink_hiz_o;
    int         mismatches = 0, comparisons = 0, cycles = 0;
    logic [7:0] d;
    logic       ok;
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
    mismatches++; $display("wrong value at %0t: got %h want %h", \
    $time, got, exp); end end

    lpc_i2c_host host (.dev_oe_n_i(sda_oe_n_o), .scl_o(scl_i), .sda_o(sda_i));
    lpc_led_ctrl #(.PUMP_DELAY_CYC(PD)) DUT (.ref_clk_i, .rst_i, .scl_i,
        .sda_i, .sda_oe_n_o, .enable_i, .supply_low_lockout_i,
        .regulation_ok_i, .pair_one_code_o, .pair_two_code_o,
        .pair_three_code_o, .sink_on_o, .sink_hiz_o, .pump_1p5x_o);
    // --------
    // clock, timeout, helpers
    // --------
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // --------
    // scenarios
    // --------
    task automatic t_reset;
        `CHK(sink_hiz_o, 6'h3f)
        `CHK(pump_1p5x_o, 1'b0)
        rst_i = 1'b0;
        enable_i = 1'b1;
        cyc(6);
        `CHK(sink_hiz_o, 6'h00)
        for (int a = 0; a < 4; a++) begin
            host.read(8'(a), d);
            `CHK(d, 8'h00)
        end
    endtask
    task automatic t_regs;
        host.write(7'h66, 8'h00, 8'hff, ok);
        `CHK(ok, 1'b1)
        host.write(7'h66, 8'h01, 8'h40, ok);
        host.write(7'h66, 8'h02, 8'h27, ok);
        host.write(7'h66, 8'h03, 8'he9, ok);
        cyc(2);
        `CHK(pair_one_code_o, 6'h3f)
        `CHK(pair_two_code_o, 6'h00)
        `CHK(pair_three_code_o, 6'h27)
        `CHK(sink_on_o, 6'h29)
        host.read(8'h02, d);
        `CHK(d[5:0], 6'h27)
        host.read(8'h03, d);
        `CHK(d[5:0], 6'h29)
    endtask
    task automatic t_refuse;
        host.write(7'h67, 8'h00, 8'h11, ok);
        `CHK(ok, 1'b0)
        host.write(7'h66, 8'h05, 8'h15, ok);
        `CHK(ok, 1'b1)
        host.read(8'h05, d);
        `CHK(d, 8'h00)
        `CHK(pair_one_code_o, 6'h3f)
    endtask
    task automatic t_pump;
        regulation_ok_i = 1'b0;
        cyc(PD / 2);
        `CHK(pump_1p5x_o, 1'b0)
        cyc(PD);
        `CHK(pump_1p5x_o, 1'b1)
        host.write(7'h66, 8'h03, 8'h3f, ok);
        `CHK(pump_1p5x_o, 1'b0)
        regulation_ok_i = 1'b1;
        cyc(3 * PD);
        `CHK(pump_1p5x_o, 1'b0)
    endtask
    task automatic t_uv;
        supply_low_lockout_i = 1'b1;
        cyc(6);
        `CHK(sink_on_o, 6'h00)
        supply_low_lockout_i = 1'b0;
        cyc(6);
        `CHK(sink_on_o, 6'h3f)
    endtask
    task automatic t_shut;
        regulation_ok_i = 1'b0;
        cyc(2 * PD);
        `CHK(pump_1p5x_o, 1'b1)
        enable_i = 1'b0;
        cyc(6);
        `CHK(sink_hiz_o, 6'h3f)
        host.write(7'h66, 8'h00, 8'h2a, ok);
        `CHK(ok, 1'b0)
        regulation_ok_i = 1'b1;
        enable_i = 1'b1;
        cyc(6);
        `CHK(pump_1p5x_o, 1'b0)
        `CHK(pair_one_code_o, 6'h00)
    endtask
    initial begin
        cyc(3);
        t_reset;
        t_regs;
        t_refuse;
        t_pump;
        t_uv;
        t_shut;
        wrap_up;
    end
endmodule

bind lpc_led_ctrl lpc_led_ctrl_properties #(
    .PUMP_DELAY_CYC(PUMP_DELAY_CYC)) u_props (.ref_clk_i, .rst_i, .scl_i,
    .sda_i, .sda_oe_n_o, .enable_i, .supply_low_lockout_i,
    .regulation_ok_i, .pair_one_code_o, .pair_two_code_o,
    .pair_three_code_o, .sink_on_o, .sink_hiz_o, .pump_1p5x_o);
`default_nettype wire
